// File: src/mie_core.sv
// Instruction execution core: fetch, decode and execute of the arithmetic,
// branch, bit, control and jump/call groups.
// Assumes program and data memories return read data in the same cycle as
// the address; data writes take place at the clock edge ending a write cycle.
`timescale 1ns/1ps
module mie_core
  import mie_pkg::*;
#(
  parameter int STACK_DEPTH = DEPTH_DEF
)(
  // Clock and reset
  input  logic             clk,
  input  logic             reset_n,
  // Program memory
  output logic [PC_W-1:0]  prog_addr,
  input  logic [7:0]       prog_data,
  // Data space memory
  output logic [7:0]       data_addr,
  input  logic [7:0]       data_rdata,
  output logic [7:0]       data_wdata,
  output logic             data_we,
  // Power modes
  input  logic             watchdog_sel,
  input  logic             wake,
  output logic             wait_mode,
  output logic             stop_mode,
  // Visible state
  output logic [7:0]       acc,
  output logic             carry,
  output logic             zero,
  output logic             instr_done
);

  typedef enum logic [0:0] {
    ST_RUN  = 1'b0,
    ST_HALT = 1'b1
  } mie_state_e;

  // ****************************************************************
  // State
  // ****************************************************************
  mie_state_e       st_ff,        nxt_st;
  logic [2:0]       cyc_ff,       nxt_cyc;
  logic [PC_W-1:0]  pc_ff,        nxt_pc;
  logic [PC_W-1:0]  opc_pc_ff,    nxt_opc_pc;
  logic [7:0]       ir_ff,        nxt_ir;
  logic [7:0]       b2_ff,        nxt_b2;
  logic [7:0]       b3_ff,        nxt_b3;
  logic [7:0]       acc_ff,       nxt_acc;
  logic             carry_ff,     nxt_carry;
  logic             zero_ff,      nxt_zero;
  logic             sav_c_ff,     nxt_sav_c;
  logic             sav_z_ff,     nxt_sav_z;
  logic [2:0]       sp_ff,        nxt_sp;
  logic [PC_W-1:0]  stk_ff  [STACK_DEPTH];
  logic [PC_W-1:0]  nxt_stk [STACK_DEPTH];
  logic [7:0]       daddr_ff,     nxt_daddr;
  logic [7:0]       wdata_ff,     nxt_wdata;
  logic             we_ff,        nxt_we;
  logic             wait_ff,      nxt_wait;
  logic             stop_ff,      nxt_stop;
  logic             done_ff,      nxt_done;

  mie_dec_s         dec;
  mie_alu_out_s     alu;
  logic [7:0]       alu_b;
  logic             cond_ok;
  logic [PC_W-1:0]  rel_tgt;
  logic [PC_W-1:0]  bit_tgt;
  logic [2:0]       push_idx;
  logic [2:0]       pop_idx;

  assign dec = mie_decode(ir_ff);
  assign alu_b = (dec.cls == cls_alu_imm) ? b2_ff : data_rdata;

  mie_alu u_alu (
    .op  (dec.op),
    .acc (acc_ff),
    .mem (alu_b),
    .cin (carry_ff),
    .out (alu)
  );

  // ****************************************************************
  // Branch conditions, targets and stack indices
  // ****************************************************************
  always_comb begin
    case (dec.cond)
      COND_BRANCH_ON_ZERO_CLEAR:  cond_ok = ~zero_ff;
      COND_BRANCH_ON_CARRY_CLEAR: cond_ok = ~carry_ff;
      COND_BRANCH_ON_ZERO_SET:    cond_ok = zero_ff;
      COND_BRANCH_ON_CARRY_SET:   cond_ok = carry_ff;
      default:                    cond_ok = 1'b0;
    endcase
    rel_tgt = dec.back ? (opc_pc_ff - {8'h00, dec.hi}) : (opc_pc_ff + {8'h00, dec.hi} + 12'h001);
    bit_tgt = opc_pc_ff + 12'h002 + {{4{b3_ff[7]}}, b3_ff};
    push_idx = (sp_ff == 3'(STACK_DEPTH)) ? 3'(STACK_DEPTH - 1) : sp_ff;
    pop_idx = (sp_ff == 3'h0) ? 3'h0 : sp_ff - 3'h1;
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_cyc = cyc_ff;
    nxt_pc = pc_ff;
    nxt_opc_pc = opc_pc_ff;
    nxt_ir = ir_ff;
    nxt_b2 = b2_ff;
    nxt_b3 = b3_ff;
    nxt_acc = acc_ff;
    nxt_carry = carry_ff;
    nxt_zero = zero_ff;
    nxt_sav_c = sav_c_ff;
    nxt_sav_z = sav_z_ff;
    nxt_sp = sp_ff;
    nxt_stk = stk_ff;
    nxt_daddr = daddr_ff;
    nxt_wdata = wdata_ff;
    nxt_we = 1'b0;
    nxt_wait = wait_ff;
    nxt_stop = stop_ff;
    nxt_done = 1'b0;
    case (st_ff)
      ST_HALT: begin
        if (wake) begin
          nxt_st = ST_RUN;
          nxt_wait = 1'b0;
          nxt_stop = 1'b0;
          nxt_cyc = 3'h0;
        end
      end
      ST_RUN: begin
        nxt_cyc = cyc_ff + 3'h1;
        case (cyc_ff)
          3'h0: begin
            nxt_ir = prog_data;
            nxt_opc_pc = pc_ff;
            nxt_pc = pc_ff + 12'h001;
          end
          3'h1: begin
            if (dec.nbytes != 2'h1) begin
              nxt_b2 = prog_data;
              nxt_pc = pc_ff + 12'h001;
            end
            if (dec.cls == cls_branch && cond_ok) begin
              nxt_pc = rel_tgt;
            end
            if (dec.cls == cls_ctrl && (dec.hi == CTRL_RET || dec.hi == CTRL_EXIT)) begin
              nxt_pc = stk_ff[pop_idx];
              nxt_sp = pop_idx;
              if (dec.hi == CTRL_EXIT) begin
                nxt_carry = sav_c_ff;
                nxt_zero = sav_z_ff;
              end
            end
            if (dec.cls == cls_alu_ind) begin
              nxt_daddr = dec.ptr_sel ? PTR_Y_ADDR : PTR_X_ADDR;
            end
            if (dec.cls == cls_acc) begin
              nxt_acc = alu.res;
              nxt_carry = alu.c;
              nxt_zero = alu.z;
            end
          end
          3'h2: begin
            if (dec.cls == cls_bit_test) begin
              nxt_b3 = prog_data;
              nxt_pc = pc_ff + 12'h001;
            end
            if (dec.cls == cls_bit_test || dec.cls == cls_bit_op || dec.cls == cls_alu_dir) begin
              nxt_daddr = b2_ff;
            end
            if (dec.cls == cls_alu_ind) begin
              nxt_daddr = data_rdata;
            end
          end
          3'h3: begin
            if (dec.cls == cls_alu_ind || dec.cls == cls_alu_dir || dec.cls == cls_alu_imm) begin
              if (dec.op >= op_count_up) begin
                nxt_wdata = alu.res;
                nxt_we = 1'b1;
              end else if (dec.op != op_accumulator_compare) begin
                nxt_acc = alu.res;
              end
              if (alu.upd_z) begin
                nxt_zero = alu.z;
              end
              if (alu.upd_c) begin
                nxt_carry = alu.c;
              end
            end
            if (dec.cls == cls_bit_op) begin
              nxt_wdata = data_rdata;
              nxt_wdata[dec.bitsel] = dec.bitval;
              nxt_we = 1'b1;
            end
            if (dec.cls == cls_bit_test) begin
              nxt_carry = data_rdata[dec.bitsel];
            end
            if (dec.cls == cls_call || dec.cls == cls_long_jump) begin
              nxt_pc = {dec.hi, b2_ff};
            end
            if (dec.cls == cls_call) begin
              nxt_stk[push_idx] = pc_ff;
              nxt_sav_c = carry_ff;
              nxt_sav_z = zero_ff;
              if (sp_ff != 3'(STACK_DEPTH)) begin
                nxt_sp = sp_ff + 3'h1;
              end
            end
          end
          default: begin
            if (dec.cls == cls_bit_test && carry_ff == dec.bitval) begin
              nxt_pc = bit_tgt;
            end
          end
        endcase
        if (cyc_ff != 3'h0 && cyc_ff == dec.ncyc - 3'h1) begin
          nxt_cyc = 3'h0;
          nxt_done = 1'b1;
          if (dec.cls == cls_ctrl && (dec.hi == CTRL_STOP || dec.hi == CTRL_WAIT)) begin
            nxt_st = ST_HALT;
            nxt_stop = (dec.hi == CTRL_STOP) && !watchdog_sel;
            nxt_wait = (dec.hi == CTRL_WAIT) || watchdog_sel;
          end
        end
      end
      default: begin
        nxt_st = ST_RUN;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= ST_RUN;
      cyc_ff <= 3'h0;
      pc_ff <= RESET_PC;
      opc_pc_ff <= RESET_PC;
      ir_ff <= 8'h00;
      b2_ff <= 8'h00;
      b3_ff <= 8'h00;
      acc_ff <= 8'h00;
      carry_ff <= 1'b0;
      zero_ff <= 1'b0;
      sav_c_ff <= 1'b0;
      sav_z_ff <= 1'b0;
      sp_ff <= 3'h0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stk_ff[i] <= RESET_PC;
      end
      daddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      we_ff <= 1'b0;
      wait_ff <= 1'b0;
      stop_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cyc_ff <= nxt_cyc;
      pc_ff <= nxt_pc;
      opc_pc_ff <= nxt_opc_pc;
      ir_ff <= nxt_ir;
      b2_ff <= nxt_b2;
      b3_ff <= nxt_b3;
      acc_ff <= nxt_acc;
      carry_ff <= nxt_carry;
      zero_ff <= nxt_zero;
      sav_c_ff <= nxt_sav_c;
      sav_z_ff <= nxt_sav_z;
      sp_ff <= nxt_sp;
      stk_ff <= nxt_stk;
      daddr_ff <= nxt_daddr;
      wdata_ff <= nxt_wdata;
      we_ff <= nxt_we;
      wait_ff <= nxt_wait;
      stop_ff <= nxt_stop;
      done_ff <= nxt_done;
    end
  end

  assign prog_addr = pc_ff;
  assign data_addr = daddr_ff;
  assign data_wdata = wdata_ff;
  assign data_we = we_ff;
  assign wait_mode = wait_ff;
  assign stop_mode = stop_ff;
  assign acc = acc_ff;
  assign carry = carry_ff;
  assign zero = zero_ff;
  assign instr_done = done_ff;

endmodule

// File: src/mie_pkg.sv
// Constants, types and decoding shared by the instruction execution core.
// Assumes one core clock and memories that answer combinationally.
package mie_pkg;

  // ****************************************************************
  // Sizes, addresses and cycle counts
  // ****************************************************************
  localparam int         PC_W        = 12;
  localparam int         DEPTH_DEF   = 6;
  localparam logic [11:0] RESET_PC   = 12'h000;
  localparam logic [7:0] PTR_X_ADDR  = 8'h80;
  localparam logic [7:0] PTR_Y_ADDR  = 8'h81;
  localparam logic [2:0] CYC_SHORT   = 3'h2;
  localparam logic [2:0] CYC_BITBR   = 3'h5;
  localparam logic [2:0] CYC_LONG    = 3'h4;

  // ****************************************************************
  // Opcode low nibble groups and control codes (high nibble)
  // ****************************************************************
  localparam logic [3:0] LO_CALL     = 4'h1;
  localparam logic [3:0] LO_BITBR    = 4'h3;
  localparam logic [3:0] LO_CTRL     = 4'h5;
  localparam logic [3:0] LO_IND      = 4'h7;
  localparam logic [3:0] LO_JUMP     = 4'h9;
  localparam logic [3:0] LO_BITOP    = 4'hb;
  localparam logic [3:0] LO_ACC      = 4'hd;
  localparam logic [3:0] LO_DIR      = 4'hf;
  localparam logic [3:0] CTRL_RET    = 4'h1;
  localparam logic [3:0] CTRL_EXIT   = 4'h2;
  localparam logic [3:0] CTRL_STOP   = 4'h3;
  localparam logic [3:0] CTRL_WAIT   = 4'h4;

  typedef enum logic [3:0] {
    op_sum                        = 4'h0,
    op_conj                       = 4'h1,
    op_accumulator_compare        = 4'h2,
    op_diff                       = 4'h3,
    op_count_up                   = 4'h4,
    op_count_down_operand         = 4'h5,
    op_zero_operand               = 4'h6,
    op_bitwise_invert_accumulator = 4'h7,
    op_rotate_left_through_carry  = 4'h8,
    op_shift_left_accumulator     = 4'h9
  } mie_alu_op_e;

  typedef enum logic [3:0] {
    cls_nop       = 4'h0,
    cls_branch    = 4'h1,
    cls_call      = 4'h2,
    cls_long_jump = 4'h3,
    cls_bit_test  = 4'h4,
    cls_bit_op    = 4'h5,
    cls_ctrl      = 4'h6,
    cls_alu_ind   = 4'h7,
    cls_alu_dir   = 4'h8,
    cls_alu_imm   = 4'h9,
    cls_acc       = 4'ha
  } mie_cls_e;

  // Branch condition codes, opcode bits 2:1
  localparam logic [1:0] COND_BRANCH_ON_ZERO_CLEAR  = 2'h0;
  localparam logic [1:0] COND_BRANCH_ON_CARRY_CLEAR = 2'h1;
  localparam logic [1:0] COND_BRANCH_ON_ZERO_SET    = 2'h2;
  localparam logic [1:0] COND_BRANCH_ON_CARRY_SET   = 2'h3;

  typedef struct packed {
    mie_cls_e    cls;
    mie_alu_op_e op;
    logic [1:0]  cond;
    logic        back;
    logic [2:0]  bitsel;
    logic        bitval;
    logic        ptr_sel;
    logic [3:0]  hi;
    logic [1:0]  nbytes;
    logic [2:0]  ncyc;
  } mie_dec_s;

  typedef struct packed {
    logic [7:0] res;
    logic       z;
    logic       c;
    logic       upd_z;
    logic       upd_c;
  } mie_alu_out_s;

  // ****************************************************************
  // Opcode decoding
  // ****************************************************************
  function automatic mie_dec_s mie_decode(input logic [7:0] opc);
    mie_dec_s   d;
    logic [3:0] lo;
    logic [3:0] hi;
    lo = opc[3:0];
    hi = opc[7:4];
    d = '{cls: cls_nop, op: op_sum, cond: lo[2:1], back: lo[3], bitsel: hi[3:1], bitval: hi[0],
          ptr_sel: hi[0], hi: hi, nbytes: 2'h1, ncyc: CYC_SHORT};
    if (!lo[0]) begin
      d.cls = cls_branch;
    end else begin
      case (lo)
        LO_CALL, LO_JUMP: begin
          d.cls    = (lo == LO_CALL) ? cls_call : cls_long_jump;
          d.nbytes = 2'h2;
          d.ncyc   = CYC_LONG;
        end
        LO_BITBR: begin
          d.cls    = cls_bit_test;
          d.nbytes = 2'h3;
          d.ncyc   = CYC_BITBR;
        end
        LO_BITOP: begin
          d.cls    = cls_bit_op;
          d.nbytes = 2'h2;
          d.ncyc   = CYC_LONG;
        end
        LO_CTRL: begin
          d.cls = cls_ctrl;
        end
        LO_IND: begin
          if (hi[3:1] != 3'h7) begin
            d.cls  = cls_alu_ind;
            d.op   = mie_alu_op_e'({1'b0, hi[3:1]});
            d.ncyc = CYC_LONG;
          end
        end
        LO_DIR: begin
          if (hi[3:1] != 3'h7 && (!hi[0] || !hi[3])) begin
            d.cls    = hi[0] ? cls_alu_imm : cls_alu_dir;
            d.op     = mie_alu_op_e'({1'b0, hi[3:1]});
            d.nbytes = 2'h2;
            d.ncyc   = CYC_LONG;
          end
        end
        LO_ACC: begin
          if (hi[1:0] != 2'h3) begin
            d.cls  = cls_acc;
            d.op   = mie_alu_op_e'(4'h7 + {2'h0, hi[1:0]});
            d.ncyc = CYC_LONG;
          end
        end
        default: begin
          d.cls = cls_nop;
        end
      endcase
    end
    return d;
  endfunction

endpackage

// File: src/mie_alu.sv
// Arithmetic and logic unit of the instruction execution core.
// Purely combinational; the caller decides where the result goes.
`timescale 1ns/1ps
module mie_alu
  import mie_pkg::*;
(
  // Operation and operands
  input  mie_alu_op_e  op,
  input  logic [7:0]   acc,
  input  logic [7:0]   mem,
  input  logic         cin,
  // Result and flags
  output mie_alu_out_s out
);

  logic [8:0] t;

  always_comb begin
    t = 9'h000;
    out = '{res: acc, z: 1'b0, c: cin, upd_z: 1'b1, upd_c: 1'b1};
    case (op)
      op_sum: begin
        t = {1'b0, acc} + {1'b0, mem};
        out.res = t[7:0];
        out.c = t[8];
      end
      op_conj: begin
        out.res = acc & mem;
        out.c = 1'b0;
      end
      op_accumulator_compare, op_diff: begin
        t = {1'b0, acc} - {1'b0, mem};
        out.res = t[7:0];
        out.c = t[8];
      end
      op_count_up: begin
        out.res = mem + 8'h01;
        out.upd_c = 1'b0;
      end
      op_count_down_operand: begin
        out.res = mem - 8'h01;
        out.upd_c = 1'b0;
      end
      op_zero_operand: begin
        out.res = 8'h00;
        out.upd_z = 1'b0;
        out.upd_c = 1'b0;
      end
      op_bitwise_invert_accumulator: begin
        out.res = ~acc;
        out.c = acc[7];
      end
      op_rotate_left_through_carry: begin
        out.res = {acc[6:0], cin};
        out.c = acc[7];
      end
      op_shift_left_accumulator: begin
        out.res = {acc[6:0], 1'b0};
        out.c = acc[7];
      end
      default: begin
        out.upd_z = 1'b0;
        out.upd_c = 1'b0;
      end
    endcase
    out.z = (out.res == 8'h00);
  end

endmodule

// File: test/mie_chk.sv
// Checker for the execution core: timing, targets and flag effects.
// Assumes it is bound to mie_core and sees only the core's ports.
`timescale 1ns/1ps
module mie_chk
  import mie_pkg::*;
#(
  parameter int STACK_DEPTH = DEPTH_DEF
)(
  // Clock and reset
  input logic            clk,
  input logic            reset_n,
  // Memories
  input logic [PC_W-1:0] prog_addr,
  input logic [7:0]      prog_data,
  input logic [7:0]      data_addr,
  input logic [7:0]      data_rdata,
  input logic [7:0]      data_wdata,
  input logic            data_we,
  // Modes and state
  input logic            watchdog_sel,
  input logic            wake,
  input logic            wait_mode,
  input logic            stop_mode,
  input logic [7:0]      acc,
  input logic            carry,
  input logic            zero,
  input logic            instr_done
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic            first_ff;
  logic [31:0]     hist_ff;
  logic            start;
  logic            cond;
  logic [PC_W-1:0] br_tgt;
  logic [7:0]      bo_w;
  logic            tbit;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_ff <= 1'b1;
      hist_ff  <= 32'h0;
    end else begin
      first_ff <= 1'b0;
      hist_ff  <= {hist_ff[23:0], prog_data};
    end
  end
  // Opcode cycle of an instruction, halt cycles left out
  assign start = (instr_done || first_ff) && !wait_mode && !stop_mode;
  assign tbit  = data_rdata[hist_ff[23:21]];
  always_comb begin
    bo_w = data_rdata;
    bo_w[hist_ff[23:21]] = hist_ff[20];
    case (prog_data[2:1])
      2'h0: cond = !zero;
      2'h1: cond = !carry;
      2'h2: cond = zero;
      default: cond = carry;
    endcase
    if (!cond) br_tgt = prog_addr + 12'h001;
    else if (prog_data[3]) br_tgt = prog_addr - {8'h00, prog_data[7:4]};
    else br_tgt = prog_addr + {8'h00, prog_data[7:4]} + 12'h001;
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  branch_target_a: assert property (
    start && !prog_data[0] |-> ##2 instr_done && prog_addr == $past(br_tgt, 2)) else $error("branch target wrong");
  branch_flags_a: assert property (
    start && !prog_data[0] |-> ##2 carry == $past(carry, 2) && zero == $past(zero, 2)) else $error("branch flags moved");
  bit_test_a: assert property (
    start && prog_data[3:0] == LO_BITBR |-> ##5 instr_done && carry == $past(tbit, 2)) else $error("tested bit lost");
  long_target_a: assert property (
    start && prog_data[2:0] == 3'h1 |-> ##4 instr_done && prog_addr == {hist_ff[31:28], hist_ff[23:16]})
    else $error("jump target wrong");
  bit_write_a: assert property (
    start && prog_data[3:0] == LO_BITOP |-> ##4 data_we && data_wdata == $past(bo_w) && carry == $past(carry, 4))
    else $error("bit write wrong");
  count_carry_a: assert property (
    start && prog_data[7:6] == 2'h2 && (prog_data[3:0] == LO_IND || prog_data[3:0] == LO_DIR && !prog_data[4])
    |-> ##4 carry == $past(carry, 4)) else $error("count op moved carry");
  ptr_select_a: assert property (
    start && prog_data[3:0] == LO_IND && prog_data[7:5] != 3'h7 |-> ##2 data_addr == {7'h40, hist_ff[12]})
    else $error("pointer choice wrong");
  stop_halt_a: assert property (
    start && prog_data == {CTRL_STOP, LO_CTRL} ##1 !watchdog_sel |=> stop_mode && !wait_mode)
    else $error("stop not entered");
  stop_wait_a: assert property (
    start && prog_data == {CTRL_STOP, LO_CTRL} ##1 watchdog_sel |=> wait_mode && !stop_mode)
    else $error("stop not replaced by wait");
  done_pulse_a: assert property (
    $rose(instr_done) |=> !instr_done) else $error("done pulse too long");
  cover property (start && !prog_data[0] && cond);
  cover property (start && prog_data[3:0] == LO_BITBR);
  cover property (wait_mode && wake);
endmodule

bind mie_core mie_chk #(.STACK_DEPTH(STACK_DEPTH)) i_mie_chk (
  .clk(clk), .reset_n(reset_n), .prog_addr(prog_addr), .prog_data(prog_data),
  .data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we),
  .watchdog_sel(watchdog_sel), .wake(wake), .wait_mode(wait_mode), .stop_mode(stop_mode),
  .acc(acc), .carry(carry), .zero(zero), .instr_done(instr_done)
);

// File: test/mie_mem.sv
// Program and data space model answering in the same cycle.
// Assumes a write lands at the rising edge ending a strobed cycle.
`timescale 1ns/1ps
module mie_mem (
  // Clock
  input  logic        clk,
  // Program space
  input  logic [11:0] prog_addr,
  output logic [7:0]  prog_data,
  // Data space
  input  logic [7:0]  data_addr,
  output logic [7:0]  data_rdata,
  input  logic [7:0]  data_wdata,
  input  logic        data_we
);
  logic [7:0] pmem [4096];
  logic [7:0] dmem [256];
  initial begin
    foreach (dmem[i]) dmem[i] = 8'h00;
  end
  assign prog_data  = pmem[prog_addr];
  assign data_rdata = dmem[data_addr];
  always @(posedge clk) begin
    if (data_we) dmem[data_addr] <= data_wdata;
  end
endmodule

// File: test/tb_mcu_core_instruction_exec.sv
// Self-checking bench for the execution core and its memory model.
// Assumes the core restarts at 000 on reset and fetches combinationally.
`timescale 1ns/1ps
module tb_mcu_core_instruction_exec;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        watchdog_sel = 1'b0;
  logic        wake = 1'b0;
  logic [11:0] prog_addr;
  logic [7:0]  prog_data, data_addr, data_rdata, data_wdata, acc;
  logic        data_we, wait_mode, stop_mode, carry, zero, instr_done;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [31:0] seed = 32'h0000_000e;

  mie_core #(.STACK_DEPTH(6)) i_mie_core (
    .clk(clk), .reset_n(reset_n), .prog_addr(prog_addr), .prog_data(prog_data),
    .data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we),
    .watchdog_sel(watchdog_sel), .wake(wake), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .acc(acc), .carry(carry), .zero(zero), .instr_done(instr_done));
  mie_mem i_mie_mem (
    .clk(clk), .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
    .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Flags and accumulator after adding a to a cleared core, then op with b
  function automatic logic [9:0] alu_ref(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    case (op)
      4'h0: s = {1'b0, a} + {1'b0, b};
      4'h1: s = {1'b0, a & b};
      4'h2, 4'h3: s = {a < b, a - b};
      4'h7: s = {a[7], ~a};
      default: s = {a[7], a[6:0], 1'b0};
    endcase
    return {s[8], s[7:0] == 8'h00, (op == 4'h2) ? a : s[7:0]};
  endfunction
  task automatic chk(input logic [11:0] e, input logic [11:0] a);
    comparisons++;
    if (a !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task automatic prep(input logic [7:0] q [$]);
    reset_n = 1'b0;
    foreach (i_mie_mem.pmem[i]) i_mie_mem.pmem[i] = 8'h05;
    foreach (q[i]) i_mie_mem.pmem[i] = q[i];
  endtask
  // Runs n instructions; ends in the opcode cycle of the next one
  task automatic go(input int n);
    int k;
    @(negedge clk);
    reset_n = 1'b1;
    repeat (n) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (instr_done !== 1'b1 && k < 20);
      if (k == 20) num_errors++;
    end
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [7:0]  a, b, r, o, e;
    logic [8:0]  s;
    logic [3:0]  op;
    logic [11:0] t;
    logic        tk;
    repeat (12) @(negedge clk);
    for (int k = 0; k < 40; k++) begin
      a = (k == 0) ? 8'hff : rnd();
      b = (k < 2) ? ((k == 0) ? 8'h01 : a) : rnd();
      r = rnd() & 8'h7f;
      op = (k < 2) ? {2'h0, k[0], 1'b0} : 4'(rnd() % 7);
      if (op > 4'h3) op += 4'h3;
      o = rnd();
      i_mie_mem.dmem[r] = b;
      i_mie_mem.dmem[{7'h40, o[0]}] = r;
      if (op > 4'h3) prep('{8'h1f, a, {op - 4'h7, 4'hd}});
      else if (o[2:1] == 2'h0) prep('{8'h1f, a, {op[2:0], 1'b1, 4'hf}, b});
      else if (o[2:1] == 2'h1) prep('{8'h1f, a, {op[2:0], 1'b0, 4'hf}, r});
      else prep('{8'h1f, a, {op[2:0], o[0], 4'h7}});
      go(2);
      chk({2'h0, alu_ref(op, a, b)}, {2'h0, carry, zero, acc});
    end
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      b = (k == 0) ? 8'hff : rnd();
      op = 4'h8 + 4'(2 * (k % 3));
      i_mie_mem.dmem[r] = b;
      prep('{8'h1f, 8'h80, 8'h1f, 8'h80, {op, 4'hf}, r});
      go(3);
      @(negedge clk);
      e = (op == 4'h8) ? b + 8'h01 : (op == 4'ha) ? b - 8'h01 : 8'h00;
      chk({4'h0, e}, {4'h0, i_mie_mem.dmem[r]});
      chk({2'h0, 1'b1, (op == 4'hc) || (e == 8'h00), 8'h00}, {2'h0, carry, zero, acc});
    end
    for (int k = 0; k < 24; k++) begin
      a = (k == 0) ? 8'h80 : rnd();
      b = (k == 0) ? 8'h80 : rnd();
      o = rnd() & 8'hfe;
      s = {1'b0, a} + {1'b0, b};
      case (o[2:1])
        2'h0: tk = s[7:0] != 8'h00;
        2'h1: tk = !s[8];
        2'h2: tk = s[7:0] == 8'h00;
        default: tk = s[8];
      endcase
      prep('{8'h1f, a, 8'h1f, b, 8'h09, 8'h40});
      i_mie_mem.pmem[12'h040] = o;
      t = !tk ? 12'h041 : o[3] ? 12'h040 - {8'h00, o[7:4]} : 12'h041 + {8'h00, o[7:4]};
      go(4);
      chk(t, prog_addr);
    end
    for (int k = 0; k < 24; k++) begin
      b = rnd();
      r = rnd() & 8'h7f;
      o = {rnd() & 8'hf0} | ((k < 12) ? 8'h03 : 8'h0b);
      e = (k == 0) ? 8'h80 : (k == 1) ? 8'h7f : rnd();
      i_mie_mem.dmem[r] = b;
      prep('{8'h19, 8'h00});
      i_mie_mem.pmem[12'h100] = o;
      i_mie_mem.pmem[12'h101] = r;
      i_mie_mem.pmem[12'h102] = e;
      go(2);
      tk = b[o[7:5]];
      if (k < 12) begin
        chk({11'h0, tk}, {11'h0, carry});
        chk((tk == o[4]) ? 12'h102 + {{4{e[7]}}, e} : 12'h103, prog_addr);
      end else begin
        // Write lands at the edge ending the next opcode cycle
        @(negedge clk);
        b[o[7:5]] = o[4];
        chk({4'h0, b}, {4'h0, i_mie_mem.dmem[r]});
      end
    end
    for (int k = 0; k < 8; k++) begin
      // Low byte kept off the top so the routine never wraps onto 000
      t = {1'b1, 3'(rnd()), rnd() & 8'hf7};
      prep('{8'h1f, 8'h80, 8'h1f, 8'h80, {t[11:8], 4'h1}, t[7:0]});
      i_mie_mem.pmem[t] = 8'h1f;
      i_mie_mem.pmem[t + 12'h001] = 8'h01;
      i_mie_mem.pmem[t + 12'h002] = 8'h25;
      go(3);
      chk(t, prog_addr);
      go(2);
      chk(12'h003, {10'h0, carry, zero});
    end
    for (int k = 0; k < 3; k++) begin
      watchdog_sel = (k == 1);
      prep('{(k == 2) ? 8'h45 : 8'h35, 8'h05});
      go(0);
      repeat (3) @(negedge clk);
      chk({10'h0, k != 0, k == 0}, {10'h0, wait_mode, stop_mode});
      wake = 1'b1;
      @(negedge clk);
      wake = 1'b0;
      repeat (2) @(negedge clk);
      chk(12'h000, {10'h0, wait_mode, stop_mode});
    end
    test_done();
  end
endmodule
